/* hw/uhtd_regs.vh */
// register map, header size, result codes and reset values of the descriptor engine
`ifndef UHTD_REGS_VH
`define UHTD_REGS_VH

// wishbone byte offsets
`define UHTD_LIST_BUFFER_STATE 8'h00
`define UHTD_APERIODIC_BLOCK_SIZE 8'h04
`define UHTD_INTERRUPT_BLOCK_SIZE 8'h08
`define UHTD_APERIODIC_SKIP_BITS 8'h0C
`define UHTD_INTERRUPT_SKIP_BITS 8'h10
`define UHTD_APERIODIC_LAST_INDEX 8'h14
`define UHTD_INTERRUPT_LAST_INDEX 8'h18
`define UHTD_ISO_ZERO_BASE 8'h20
`define UHTD_ISO_ONE_BASE 8'h24
`define UHTD_INTERRUPT_BASE 8'h28
`define UHTD_APERIODIC_BASE 8'h2C
`define UHTD_ENGINE_STATE 8'h30

// list_buffer_state bits, also the list numbers in scan order
`define UHTD_ISO_ZERO_FULL 0
`define UHTD_ISO_ONE_FULL 1
`define UHTD_INTERRUPT_LIST_ON 2
`define UHTD_APERIODIC_LIST_ON 3

// reset values
`define UHTD_RST_BUFFER_STATE 4'h0
`define UHTD_RST_BLOCK_SIZE 10'h000
`define UHTD_RST_SKIP 32'h0000_0000
`define UHTD_RST_LAST 5'h00

// descriptor header geometry
`define UHTD_HDR_BYTES 8

// result_code values
`define UHTD_RC_OK 4'h0
`define UHTD_RC_CRC 4'h1
`define UHTD_RC_STUFF 4'h2
`define UHTD_RC_TOGGLE 4'h3
`define UHTD_RC_STALL 4'h4
`define UHTD_RC_NO_RESPONSE 4'h5
`define UHTD_RC_PID_CHECK 4'h6
`define UHTD_RC_BAD_PID 4'h7
`define UHTD_RC_OVERRUN 4'h8
`define UHTD_RC_UNDERRUN 4'h9
`define UHTD_RC_RSVD_A 4'hA
`define UHTD_RC_RSVD_B 4'hB
`define UHTD_RC_IN_TOO_FAST 4'hC
`define UHTD_RC_OUT_TOO_SLOW 4'hD

// direction_token values
`define UHTD_TOKEN_SETUP 2'h0
`define UHTD_TOKEN_OUT 2'h1
`define UHTD_TOKEN_IN 2'h2

`endif

/* hw/uhtd_engine.v */
// transfer descriptor engine: list walker, header decode, result write-back, wishbone registers
`timescale 1ns/1ps
`include "uhtd_regs.vh"

module uhtd_engine #(
  parameter AW = 12
) (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg mem_req_o,
  output reg mem_we_o,
  output reg [AW-1:0] mem_addr_o,
  output reg [31:0] mem_wdata_o,
  input wire [31:0] mem_rdata_i,
  input wire mem_ack_i,
  input wire [10:0] frame_num_i,
  output reg txn_req_o,
  output reg [1:0] txn_token_o,
  output reg [6:0] txn_dev_addr_o,
  output reg [3:0] txn_endpoint_o,
  output reg txn_low_speed_o,
  output reg txn_toggle_o,
  output reg txn_iso_o,
  output reg [9:0] txn_len_o,
  output reg [AW-1:0] txn_buf_addr_o,
  input wire txn_done_i,
  input wire [3:0] txn_result_i,
  input wire [10:0] txn_count_i
);

  localparam S_IDLE = 4'h0;
  localparam S_LIST = 4'h1;
  localparam S_SEL = 4'h2;
  localparam S_RD0 = 4'h3;
  localparam S_RD1 = 4'h4;
  localparam S_CHK = 4'h5;
  localparam S_TXN = 4'h6;
  localparam S_WB = 4'h7;
  localparam S_ADV = 4'h8;
  localparam S_NXL = 4'h9;

  localparam [AW-1:0] HDR = `UHTD_HDR_BYTES;
  localparam [1:0] L_ISO0 = `UHTD_ISO_ZERO_FULL;
  localparam [1:0] L_ISO1 = `UHTD_ISO_ONE_FULL;
  localparam [1:0] L_INT = `UHTD_INTERRUPT_LIST_ON;
  localparam [1:0] L_ATL = `UHTD_APERIODIC_LIST_ON;

  // software registers
  reg [3:0] on_q;
  reg [9:0] atl_blk_q;
  reg [9:0] int_blk_q;
  reg [31:0] atl_skip_q;
  reg [31:0] int_skip_q;
  reg [4:0] atl_last_q;
  reg [4:0] int_last_q;
  reg [AW-1:0] base_q [0:3];

  // engine state
  reg [3:0] st_q;
  reg [1:0] list_q;
  reg [4:0] idx_q;
  reg [AW-1:0] off_q;
  reg [31:0] w0_q;
  reg [31:0] w1_q;
  reg pong_ok_q;
  reg [3:0] last_code_q;
  reg iso_done_q;

  // header fields, word 0 = bytes 0..3, word 1 = bytes 4..7, byte 0 in bits 7:0
  wire [9:0] f_count = w0_q[9:0];
  wire f_toggle = w0_q[10];
  wire f_active = w0_q[11];
  wire [9:0] f_max_len = {w0_q[25:24], w0_q[23:16]};
  wire f_speed = w0_q[26];
  wire f_last = w0_q[27];
  wire [3:0] f_endpoint = w0_q[31:28];
  wire [9:0] f_req_len = w1_q[9:0];
  wire [1:0] f_token = w1_q[11:10];
  wire f_pingpong = w1_q[14];
  wire f_paired = w1_q[15];
  wire [6:0] f_dev_addr = w1_q[22:16];
  wire [7:0] f_byte7 = w1_q[31:24];

  wire is_iso = ~list_q[1];
  wire is_atl = (list_q == L_ATL);
  wire is_int = (list_q == L_INT);
  wire [9:0] blk = is_atl ? atl_blk_q : int_blk_q;
  wire [31:0] skip = is_atl ? atl_skip_q : int_skip_q;
  wire [4:0] last_idx = is_atl ? atl_last_q : int_last_q;
  wire [9:0] remain = f_req_len - f_count;

  // next offsets: fixed block or DWord-packed
  wire [AW-1:0] blk_step = HDR + {{(AW-10){1'b0}}, blk};
  wire [10:0] req_plus3 = {1'b0, f_req_len} + 11'h003;
  wire [AW-1:0] iso_step = HDR + {{(AW-11){1'b0}}, req_plus3[10:2], 2'b00};

  // polling and frame gates
  wire [2:0] poll_interval = f_byte7[7:5];
  wire [4:0] first_frame = f_byte7[4:0];
  wire [7:0] poll_mask = (8'h01 << poll_interval) - 8'h01;
  wire [7:0] frame_diff = frame_num_i[7:0] - {3'b000, first_frame};
  wire poll_due = ((frame_diff & poll_mask) == 8'h00);
  wire iso_due = (frame_num_i[4:0] == first_frame);
  wire pong_block = is_atl && f_paired && f_pingpong && !pong_ok_q;

  wire go = f_active && !pong_block && (is_int ? poll_due : 1'b1) && (is_iso ? iso_due : 1'b1);

  // result evaluation at transaction end
  reg [3:0] rc;
  reg [10:0] got_sum;
  reg [9:0] new_count;
  reg retire;
  always @* begin
    got_sum = {1'b0, f_count} + txn_count_i;
    new_count = got_sum[9:0];
    rc = `UHTD_RC_OK;
    if (txn_result_i != `UHTD_RC_OK) begin
      if (txn_result_i == `UHTD_RC_RSVD_A || txn_result_i == `UHTD_RC_RSVD_B) begin
        rc = `UHTD_RC_BAD_PID;
      end else begin
        rc = txn_result_i;
      end
    end else if (f_token == `UHTD_TOKEN_IN &&
                 (txn_count_i > {1'b0, f_max_len} || txn_count_i > {1'b0, remain})) begin
      rc = `UHTD_RC_OVERRUN;
      new_count = f_req_len;
    end else if (f_token == `UHTD_TOKEN_IN && txn_count_i < {1'b0, f_max_len} &&
                 got_sum < {1'b0, f_req_len}) begin
      rc = `UHTD_RC_UNDERRUN;
    end
    retire = is_iso || (rc != `UHTD_RC_OK) || (new_count >= f_req_len);
  end

  wire data_ok = (rc == `UHTD_RC_OK) || (rc == `UHTD_RC_UNDERRUN);
  wire wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_hit && wb_we_i;

  // wishbone slave, one wait state, unmapped reads zero
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          `UHTD_LIST_BUFFER_STATE: wb_dat_o <= {28'h000_0000, on_q};
          `UHTD_APERIODIC_BLOCK_SIZE: wb_dat_o <= {22'h00_0000, atl_blk_q};
          `UHTD_INTERRUPT_BLOCK_SIZE: wb_dat_o <= {22'h00_0000, int_blk_q};
          `UHTD_APERIODIC_SKIP_BITS: wb_dat_o <= atl_skip_q;
          `UHTD_INTERRUPT_SKIP_BITS: wb_dat_o <= int_skip_q;
          `UHTD_APERIODIC_LAST_INDEX: wb_dat_o <= {27'h000_0000, atl_last_q};
          `UHTD_INTERRUPT_LAST_INDEX: wb_dat_o <= {27'h000_0000, int_last_q};
          `UHTD_ISO_ZERO_BASE: wb_dat_o <= {{(32-AW){1'b0}}, base_q[0]};
          `UHTD_ISO_ONE_BASE: wb_dat_o <= {{(32-AW){1'b0}}, base_q[1]};
          `UHTD_INTERRUPT_BASE: wb_dat_o <= {{(32-AW){1'b0}}, base_q[2]};
          `UHTD_APERIODIC_BASE: wb_dat_o <= {{(32-AW){1'b0}}, base_q[3]};
          `UHTD_ENGINE_STATE: wb_dat_o <= {14'h0000, pong_ok_q, last_code_q, idx_q,
                                           list_q, st_q, 2'b00};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // writable registers; byte lane 0 carries fields of 8 bits or less
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      atl_blk_q <= `UHTD_RST_BLOCK_SIZE;
      int_blk_q <= `UHTD_RST_BLOCK_SIZE;
      atl_skip_q <= `UHTD_RST_SKIP;
      int_skip_q <= `UHTD_RST_SKIP;
      atl_last_q <= `UHTD_RST_LAST;
      int_last_q <= `UHTD_RST_LAST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `UHTD_APERIODIC_BLOCK_SIZE: begin
          if (wb_sel_i[0]) atl_blk_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) atl_blk_q[9:8] <= wb_dat_i[9:8];
        end
        `UHTD_INTERRUPT_BLOCK_SIZE: begin
          if (wb_sel_i[0]) int_blk_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) int_blk_q[9:8] <= wb_dat_i[9:8];
        end
        `UHTD_APERIODIC_SKIP_BITS: begin
          if (wb_sel_i[0]) atl_skip_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) atl_skip_q[15:8] <= wb_dat_i[15:8];
          if (wb_sel_i[2]) atl_skip_q[23:16] <= wb_dat_i[23:16];
          if (wb_sel_i[3]) atl_skip_q[31:24] <= wb_dat_i[31:24];
        end
        `UHTD_INTERRUPT_SKIP_BITS: begin
          if (wb_sel_i[0]) int_skip_q[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) int_skip_q[15:8] <= wb_dat_i[15:8];
          if (wb_sel_i[2]) int_skip_q[23:16] <= wb_dat_i[23:16];
          if (wb_sel_i[3]) int_skip_q[31:24] <= wb_dat_i[31:24];
        end
        `UHTD_APERIODIC_LAST_INDEX: begin
          if (wb_sel_i[0]) atl_last_q <= wb_dat_i[4:0];
        end
        `UHTD_INTERRUPT_LAST_INDEX: begin
          if (wb_sel_i[0]) int_last_q <= wb_dat_i[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  // list base registers, one per list
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_base
      localparam integer BASE_ADR = `UHTD_ISO_ZERO_BASE + 4 * g;
      wire hit = wb_wr && (wb_adr_i == BASE_ADR[7:0]);
      always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          base_q[g] <= {AW{1'b0}};
        end else if (hit) begin
          if (wb_sel_i[0]) base_q[g][7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) base_q[g][AW-1:8] <= wb_dat_i[AW-1:8];
        end
      end
    end
  endgenerate

  // list enables; software set wins over the engine clearing an iso full bit
  wire on_wr = wb_wr && (wb_adr_i == `UHTD_LIST_BUFFER_STATE) && wb_sel_i[0];
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      on_q <= `UHTD_RST_BUFFER_STATE;
    end else if (on_wr) begin
      on_q <= wb_dat_i[3:0];
    end else if (iso_done_q) begin
      on_q[list_q] <= 1'b0;
    end
  end

  // list walker
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= S_IDLE;
      list_q <= 2'b00;
      idx_q <= 5'h00;
      off_q <= {AW{1'b0}};
      w0_q <= 32'h0000_0000;
      w1_q <= 32'h0000_0000;
      pong_ok_q <= 1'b0;
      last_code_q <= `UHTD_RC_OK;
      iso_done_q <= 1'b0;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= {AW{1'b0}};
      mem_wdata_o <= 32'h0000_0000;
      txn_req_o <= 1'b0;
      txn_token_o <= 2'b00;
      txn_dev_addr_o <= 7'h00;
      txn_endpoint_o <= 4'h0;
      txn_low_speed_o <= 1'b0;
      txn_toggle_o <= 1'b0;
      txn_iso_o <= 1'b0;
      txn_len_o <= 10'h000;
      txn_buf_addr_o <= {AW{1'b0}};
    end else begin
      iso_done_q <= 1'b0;
      case (st_q)
        S_IDLE: begin
          list_q <= L_ISO0;
          st_q <= S_LIST;
        end
        S_LIST: begin
          if (on_q[list_q] && !iso_done_q) begin
            off_q <= base_q[list_q];
            idx_q <= 5'h00;
            st_q <= S_SEL;
          end else begin
            st_q <= S_NXL;
          end
        end
        S_SEL: begin
          if (!on_q[list_q]) begin
            st_q <= S_NXL;
          end else if (!is_iso && idx_q > last_idx) begin
            st_q <= S_NXL;
          end else if (!is_iso && skip[idx_q]) begin
            off_q <= off_q + blk_step;
            idx_q <= idx_q + 5'h01;
          end else begin
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b0;
            mem_addr_o <= off_q;
            st_q <= S_RD0;
          end
        end
        S_RD0: begin
          if (mem_ack_i) begin
            w0_q <= mem_rdata_i;
            mem_addr_o <= off_q + 4'h4;
            st_q <= S_RD1;
          end
        end
        S_RD1: begin
          if (mem_ack_i) begin
            w1_q <= mem_rdata_i;
            mem_req_o <= 1'b0;
            st_q <= S_CHK;
          end
        end
        S_CHK: begin
          if (go) begin
            txn_req_o <= 1'b1;
            txn_token_o <= f_token;
            txn_dev_addr_o <= f_dev_addr;
            txn_endpoint_o <= f_endpoint;
            txn_low_speed_o <= f_speed;
            txn_toggle_o <= f_toggle;
            txn_iso_o <= is_iso;
            txn_len_o <= (remain < f_max_len) ? remain : f_max_len;
            txn_buf_addr_o <= off_q + HDR + {{(AW-10){1'b0}}, f_count};
            st_q <= S_TXN;
          end else begin
            st_q <= S_ADV;
          end
        end
        S_TXN: begin
          if (txn_done_i) begin
            txn_req_o <= 1'b0;
            last_code_q <= rc;
            w0_q[9:0] <= new_count;
            w0_q[15:12] <= rc;
            w0_q[10] <= data_ok ? ~f_toggle : f_toggle;
            w0_q[11] <= ~retire;
            if (is_atl && f_paired && !f_pingpong && data_ok) begin
              pong_ok_q <= 1'b1;
            end else if (is_atl && f_paired && f_pingpong && retire) begin
              pong_ok_q <= 1'b0;
            end
            mem_req_o <= 1'b1;
            mem_we_o <= 1'b1;
            mem_addr_o <= off_q;
            mem_wdata_o <= {w0_q[31:16], rc, ~retire, data_ok ? ~f_toggle : f_toggle,
                            new_count};
            st_q <= S_WB;
          end
        end
        S_WB: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            st_q <= S_ADV;
          end
        end
        S_ADV: begin
          if (is_iso && f_last) begin
            iso_done_q <= 1'b1;
            st_q <= S_NXL;
          end else begin
            off_q <= off_q + (is_iso ? iso_step : blk_step);
            idx_q <= idx_q + 5'h01;
            st_q <= S_SEL;
          end
        end
        S_NXL: begin
          if (list_q == L_ATL) begin
            st_q <= S_IDLE;
          end else begin
            list_q <= list_q + 2'b01;
            st_q <= S_LIST;
          end
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // uhtd_engine

/* tb/uhtd_engine_sva.sv */
// port checker for the descriptor engine
`timescale 1ns/1ps
module uhtd_engine_sva #(
  parameter AW = 12
) (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire mem_req_o,
  input wire mem_we_o,
  input wire [AW-1:0] mem_addr_o,
  input wire [31:0] mem_wdata_o,
  input wire [31:0] mem_rdata_i,
  input wire mem_ack_i,
  input wire txn_req_o,
  input wire [1:0] txn_token_o,
  input wire [6:0] txn_dev_addr_o,
  input wire [3:0] txn_endpoint_o,
  input wire txn_low_speed_o,
  input wire txn_toggle_o,
  input wire [9:0] txn_len_o,
  input wire [AW-1:0] txn_buf_addr_o,
  input wire txn_done_i,
  input wire [3:0] txn_result_i
);
  reg ph_q;
  reg [31:0] w0_q;
  reg [31:0] w1_q;
  wire [3:0] wb_code = mem_wdata_o[15:12];
  wire wb_go = mem_req_o && mem_we_o;
  wire rsv = txn_result_i == 4'hA || txn_result_i == 4'hB;
  wire [3:0] exp_code = rsv ? 4'h7 : txn_result_i;
  wire fin = txn_req_o && txn_done_i;
  // header words as the engine fetched them
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ph_q <= 1'b0;
      w0_q <= 32'h0;
      w1_q <= 32'h0;
    end else if (!mem_req_o) begin
      ph_q <= 1'b0;
    end else if (!mem_we_o && mem_ack_i) begin
      ph_q <= !ph_q;
      if (ph_q)
        w1_q <= mem_rdata_i;
      else
        w0_q <= mem_rdata_i;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("wishbone ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("wishbone ack longer than one cycle");
  a_mem_hold: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request not held");
  a_txn_hold: assert property (
    txn_req_o && !txn_done_i |=> txn_req_o && $stable(txn_buf_addr_o) && $stable(txn_len_o))
    else $error("transaction request not held");
  a_txn_close: assert property (fin |=> !txn_req_o && wb_go)
    else $error("no write-back after transaction");
  a_hdr_route: assert property (
    $rose(txn_req_o) |-> txn_token_o == w1_q[11:10] && txn_dev_addr_o == w1_q[22:16])
    else $error("token or address differs from header");
  a_speed_ep: assert property (
    $rose(txn_req_o) |-> txn_low_speed_o == w0_q[26] && txn_endpoint_o == w0_q[31:28])
    else $error("speed or endpoint differs from header");
  a_len_cap: assert property (
    $rose(txn_req_o) |-> txn_len_o <= w0_q[25:16] && txn_len_o <= w1_q[9:0])
    else $error("transaction length too large");
  a_code_pass: assert property (
    fin && txn_result_i != 4'h0 |=> wb_code == $past(exp_code))
    else $error("result code written wrong");
  a_err_retire: assert property (wb_go && wb_code != 4'h0 |-> !mem_wdata_o[11])
    else $error("failed descriptor left active");
  a_toggle_upd: assert property (
    fin |=> mem_wdata_o[10] == ($past(txn_toggle_o) ^ (wb_code == 4'h0 || wb_code == 4'h9)))
    else $error("toggle written wrong");
  cover property (fin && rsv);
  cover property (wb_go && wb_code == 4'h9);
  cover property ($rose(txn_req_o) && txn_low_speed_o);
endmodule // uhtd_engine_sva

bind uhtd_engine uhtd_engine_sva #(.AW(AW)) chk (.sys_clk_i, .rst_b_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i,
  .txn_req_o, .txn_token_o, .txn_dev_addr_o, .txn_endpoint_o, .txn_low_speed_o,
  .txn_toggle_o, .txn_len_o, .txn_buf_addr_o, .txn_done_i, .txn_result_i);

/* tb/uhtd_far_model.sv */
// buffer memory and serial engine model
`timescale 1ns/1ps
module uhtd_far_model (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire slow_i,
  input wire [3:0] res_i,
  input wire [10:0] cnt_i,
  input wire mem_req_i,
  input wire mem_we_i,
  input wire [11:0] mem_addr_i,
  input wire [31:0] mem_wdata_i,
  output logic [31:0] mem_rdata_o,
  output logic mem_ack_o,
  input wire txn_req_i,
  output logic txn_done_o,
  output logic [3:0] txn_result_o,
  output logic [10:0] txn_count_o
);
  logic [31:0] mem [0:1023];
  logic [2:0] mw_q;
  logic [2:0] tw_q;
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 32'h0;
      mw_q <= 3'h0;
    end else if (mem_req_i && !mem_ack_o && mw_q >= (slow_i ? 3'h3 : 3'h0)) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= mem[mem_addr_i[11:2]];
      if (mem_we_i)
        mem[mem_addr_i[11:2]] <= mem_wdata_i;
      mw_q <= 3'h0;
    end else begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      mw_q <= (mem_req_i && !mem_ack_o) ? mw_q + 3'h1 : 3'h0;
    end
  end
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      txn_done_o <= 1'b0;
      txn_result_o <= 4'h0;
      txn_count_o <= 11'h000;
      tw_q <= 3'h0;
    end else if (txn_req_i && !txn_done_o && tw_q >= (slow_i ? 3'h4 : 3'h1)) begin
      txn_done_o <= 1'b1;
      txn_result_o <= res_i;
      txn_count_o <= cnt_i;
      tw_q <= 3'h0;
    end else begin
      txn_done_o <= 1'b0;
      txn_result_o <= ~txn_result_o;
      txn_count_o <= ~txn_count_o;
      tw_q <= (txn_req_i && !txn_done_o) ? tw_q + 3'h1 : 3'h0;
    end
  end
endmodule // uhtd_far_model

/* tb/uhtd_engine_bench.sv */
// self-checking bench for the descriptor engine
`timescale 1ns/1ps
`include "uhtd_regs.vh"
module uhtd_engine_bench;
  logic sys_clk_i = 1'b0, rst_b_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, txn_endpoint_o, txn_result_i;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, mem_wdata_o, mem_rdata_i;
  logic wb_ack_o, mem_req_o, mem_we_o, mem_ack_i, txn_req_o, txn_done_i;
  logic txn_low_speed_o, txn_toggle_o, txn_iso_o;
  logic [11:0] mem_addr_o, txn_buf_addr_o;
  logic [10:0] frame_num_i = 11'h000, txn_count_i;
  logic [1:0] txn_token_o;
  logic [6:0] txn_dev_addr_o;
  logic [9:0] txn_len_o;
  logic slow = 1'b0;
  logic [3:0] res = 4'h0;
  logic [10:0] cnt = 11'h008;
  int fail_count = 0, n_tests = 0, cyc_n = 0;

  uhtd_engine #(.AW(12)) uut (.sys_clk_i, .rst_b_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_req_o, .mem_we_o,
    .mem_addr_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .frame_num_i, .txn_req_o,
    .txn_token_o, .txn_dev_addr_o, .txn_endpoint_o, .txn_low_speed_o, .txn_toggle_o,
    .txn_iso_o, .txn_len_o, .txn_buf_addr_o, .txn_done_i, .txn_result_i, .txn_count_i);
  uhtd_far_model pm (.sys_clk_i, .rst_b_i, .slow_i(slow), .res_i(res), .cnt_i(cnt),
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i),
    .txn_req_i(txn_req_o), .txn_done_o(txn_done_i), .txn_result_o(txn_result_i),
    .txn_count_o(txn_count_i));

  always #10 sys_clk_i = ~sys_clk_i;

  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc_n++;
    if (cyc_n == 60000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge sys_clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  function automatic logic [31:0] hdr0(input logic spd, input logic tog);
    return {4'h3, 1'b0, spd, 10'h008, 4'h0, 1'b1, tog, 10'h000};
  endfunction

  function automatic logic [31:0] hdr1(input logic [1:0] tok, input logic [6:0] dev);
    return {8'h00, 1'b0, dev, 4'h0, tok, 10'h008};
  endfunction

  // second word first, so an active first word never meets a stale second word
  task automatic put_td(input int a, input logic [31:0] w0, input logic [31:0] w1);
    pm.mem[a + 1] = w1;
    pm.mem[a] = w0;
  endtask

  task automatic wait_retire(input int a, output logic [31:0] w);
    int t;
    t = 0;
    while (pm.mem[a][11] !== 1'b0 && t < 3000) begin
      @(posedge sys_clk_i);
      t++;
    end
    w = pm.mem[a];
  endtask

  task automatic wait_txn;
    int t;
    t = 0;
    while (txn_req_o === 1'b1 && t < 3000) begin
      @(posedge sys_clk_i);
      t++;
    end
    while (txn_req_o !== 1'b1 && t < 3000) begin
      @(posedge sys_clk_i);
      t++;
    end
    chk("txn_req", 1, txn_req_o);
  endtask

  task automatic regs_reset;
    logic [31:0] rd;
    wb(1'b0, `UHTD_LIST_BUFFER_STATE, 32'h0, rd);
    chk("buffer_state", 32'h0, rd);
    wb(1'b1, `UHTD_APERIODIC_SKIP_BITS, 32'h0000_0011, rd);
    wb(1'b0, `UHTD_APERIODIC_SKIP_BITS, 32'h0, rd);
    chk("skip_bits", 32'h0000_0011, rd);
    wb(1'b0, 8'h3C, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
  endtask

  task automatic list_walk;
    logic [31:0] rd;
    int t;
    int seq [4] = '{1, 2, 3, 5};
    for (int n = 0; n < 6; n++)
      put_td(n * 4, hdr0(n[0], 1'b0), hdr1(`UHTD_TOKEN_OUT, n[6:0]));
    wb(1'b1, `UHTD_APERIODIC_BLOCK_SIZE, 32'h8, rd);
    wb(1'b1, `UHTD_APERIODIC_LAST_INDEX, 32'h5, rd);
    t = 0;
    repeat (100) begin
      @(posedge sys_clk_i);
      if (txn_req_o !== 1'b0)
        t++;
    end
    chk("idle_txn", 0, t);
    wb(1'b1, `UHTD_LIST_BUFFER_STATE, 32'h8, rd);
    foreach (seq[k]) begin
      wait_txn();
      chk("buf_addr", seq[k] * 16 + 8, txn_buf_addr_o);
      chk("dev_addr", seq[k], txn_dev_addr_o);
      chk("low_speed", seq[k] % 2, txn_low_speed_o);
    end
    wait_retire(20, rd);
    chk("wb_word", {4'h3, 2'b01, 10'h008, 4'h0, 2'b01, 10'h008}, pm.mem[4]);
    chk("skip0", 1, pm.mem[0][11]);
    chk("skip4", 1, pm.mem[16][11]);
  endtask

  task automatic result_codes;
    logic [3:0] raw, ex;
    logic [31:0] w;
    slow <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      raw = i < 7 ? 4'(i + 1) : (i < 11 ? 4'(i + 3) : 4'h0);
      ex = i == 11 ? 4'h9 : (i == 12 ? 4'h8 : ((raw == 4'hA || raw == 4'hB) ? 4'h7 : raw));
      res <= raw;
      cnt <= i == 11 ? 11'h004 : (i == 12 ? 11'h00C : 11'h008);
      @(posedge sys_clk_i);
      put_td(4, hdr0(1'b0, 1'b0), hdr1(i > 10 ? `UHTD_TOKEN_IN : `UHTD_TOKEN_OUT, 7'h01));
      wait_retire(4, w);
      chk("code", ex, w[15:12]);
      chk("toggle", i == 11, w[10]);
      if (i > 10)
        chk("count", i == 11 ? 4 : 8, w[9:0]);
    end
  endtask

  // two packed iso descriptors, the second one marked last
  task automatic iso_walk;
    logic [31:0] rd;
    res <= 4'h0;
    cnt <= 11'h008;
    put_td(12'h085, hdr0(1'b0, 1'b0) | 32'h0800_0000, hdr1(`UHTD_TOKEN_OUT, 7'h05));
    put_td(12'h080, hdr0(1'b0, 1'b0), (hdr1(`UHTD_TOKEN_OUT, 7'h04) & 32'hFFFF_FC00) | 32'h0000_000A);
    wb(1'b1, `UHTD_ISO_ZERO_BASE, 32'h0000_0200, rd);
    wb(1'b1, `UHTD_LIST_BUFFER_STATE, 32'h0000_0009, rd);
    wait_txn();
    chk("iso_addr0", 32'h0000_0208, txn_buf_addr_o);
    chk("iso_flag", 1, txn_iso_o);
    wait_txn();
    chk("iso_addr1", 32'h0000_021C, txn_buf_addr_o);
    chk("iso_dev", 5, txn_dev_addr_o);
    wait_retire(12'h085, rd);
    repeat (10) @(posedge sys_clk_i);
    wb(1'b0, `UHTD_LIST_BUFFER_STATE, 32'h0, rd);
    chk("iso_full_clr", 32'h0000_0008, rd);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    regs_reset();
    list_walk();
    result_codes();
    iso_walk();
    give_verdict();
  end
endmodule // uhtd_engine_bench
